// ==== ssd_status_display.sv ====
// Status image, lamp display and diagnostic flags of the safety input module.
// Assumes field inputs are asynchronous pins; register access over AXI4-Lite on aclk.
`timescale 1ns/100ps
`default_nettype none
`include "ssd_regs.svh"

module ssd_status_display
    import ssd_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // Field inputs from the safety circuit
    input  wire logic [11:0] pos_contact_closed,
    input  wire logic [11:0] neg_contact_closed,
    input  wire logic        reset_input_closed,
    input  wire logic        feedback_loop_closed,
    input  wire logic        first_fault_relay_driven,
    input  wire logic        second_fault_relay_driven,
    input  wire logic        safety_supply_ok,
    input  wire logic        channel_short,
    input  wire logic        ext_supply_low,
    input  wire logic        terminal_block_missing,
    input  wire logic        internal_fault,
    input  wire logic        rack_run,
    // Lamps and flags
    output logic [31:0]      display_lamp,
    output logic             run_lamp,
    output logic             error_lamp,
    output logic             io_lamp,
    output logic             module_error_flag,
    output logic [31:0]      channel_error_flag,
    output logic             irq,
    // AXI4-Lite slave
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    ssd_state_s st_r;
    ssd_state_s st_nxt;

    logic [31:0] raw_pins;
    logic [31:0] mod_stat;
    logic [31:0] chan_stat;
    logic        ext_now;
    logic        int_now;
    logic        relay_now;
    logic        wr_fire;
    logic        rd_fire;
    logic [31:0] wr_merged;

    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    function automatic logic addr_hit(input logic [11:0] a, input logic [11:0] off);
        return a[11:2] == off[11:2];
    endfunction

    // ----------------------------------------
    // Raw pin word (unregistered, input of the first synchroniser stage)
    // ----------------------------------------
    always_comb begin
        raw_pins = 32'h0000_0000;
        raw_pins[`SSD_NUM_HALF-1:0] = pos_contact_closed;
        raw_pins[`SSD_NUM_CONTACTS-1:`SSD_NUM_HALF] = neg_contact_closed;
        raw_pins[`SSD_BIT_RESET_IN] = reset_input_closed;
        raw_pins[`SSD_BIT_LOOP] = feedback_loop_closed;
        raw_pins[`SSD_BIT_RELAY] = first_fault_relay_driven & second_fault_relay_driven;
        raw_pins[`SSD_BIT_SUPPLY] = safety_supply_ok;
        raw_pins[`SSD_BIT_SHORT] = channel_short;
        raw_pins[`SSD_BIT_EXT]   = ext_supply_low | terminal_block_missing;
        raw_pins[`SSD_BIT_INT]   = internal_fault;
        raw_pins[`SSD_BIT_RUN]   = rack_run;
    end

    // Synchronised fault levels
    assign ext_now   = st_r.in_sync2[`SSD_BIT_EXT];
    assign int_now   = st_r.in_sync2[`SSD_BIT_INT];
    assign relay_now = st_r.in_sync2[`SSD_BIT_RELAY];

    // ----------------------------------------
    // Status words
    // ----------------------------------------
    always_comb begin
        mod_stat = 32'h0000_0000;
        chan_stat = 32'h0000_0000;
        mod_stat[`SSD_MOD_EXT_BIT]   = st_r.ext_fault;
        mod_stat[`SSD_MOD_INT_BIT]   = st_r.int_fault;
        chan_stat[`SSD_CHAN_EXT_BIT] = st_r.ext_fault;
        chan_stat[`SSD_CHAN_INT_BIT] = st_r.int_fault;
    end

    assign wr_fire = st_r.aw_got & st_r.w_got & ~st_r.bvalid;
    assign rd_fire = s_axi_arvalid & (st_r.rd_state == SSD_RD_IDLE);
    assign wr_merged = strb_merge(32'h0000_0000, st_r.w_data, st_r.w_strb);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic [31:0] img;
        logic [31:0] lmp;
        logic [31:0] s;
        logic [`SSD_IRQ_W-1:0] ev;
        img = 32'h0000_0000;
        lmp = 32'h0000_0000;
        s   = st_r.in_sync2;
        ev  = '0;
        st_nxt = st_r;

        st_nxt.in_sync1 = raw_pins;
        st_nxt.in_sync2 = st_r.in_sync1;

        // External flag gated by supply monitoring; internal and relay flags ungated
        st_nxt.ext_fault = ext_now & st_r.monitor_en;
        st_nxt.int_fault = int_now;
        st_nxt.relay_q   = relay_now;

        // Input image, registered once per cycle
        img[`SSD_NUM_CONTACTS-1:0] = s[`SSD_NUM_CONTACTS-1:0];
        img[`SSD_BIT_RESET_IN] = s[`SSD_BIT_RESET_IN] & s[`SSD_BIT_LOOP];
        img[`SSD_BIT_LOOP]     = s[`SSD_BIT_LOOP];
        img[`SSD_BIT_RELAY]    = s[`SSD_BIT_RELAY];
        img[`SSD_BIT_SUPPLY]   = s[`SSD_BIT_SUPPLY];
        img = img & `SSD_IMG_USED_MASK;
        if (ext_now & st_r.monitor_en) begin
            img = 32'h0000_0000;
        end
        st_nxt.image = img;

        // Lamps always show real states
        lmp[`SSD_NUM_CONTACTS-1:0] = s[`SSD_NUM_CONTACTS-1:0];
        lmp[`SSD_BIT_RESET_IN] = s[`SSD_BIT_RESET_IN] & s[`SSD_BIT_LOOP];
        lmp[`SSD_BIT_LOOP]     = s[`SSD_BIT_LOOP];
        lmp[`SSD_BIT_RELAY]    = s[`SSD_BIT_RELAY];
        lmp[`SSD_BIT_SUPPLY]   = s[`SSD_BIT_SUPPLY] & ~s[`SSD_BIT_SHORT];
        st_nxt.lamps = lmp & `SSD_IMG_USED_MASK;

        // Module lamps: run, error, I/O
        st_nxt.mod_lamps[`SSD_LAMP_RUN] = s[`SSD_BIT_RUN];
        st_nxt.mod_lamps[`SSD_LAMP_ERR] = int_now |
                                          (s[`SSD_BIT_RUN] & ext_now & s[`SSD_BIT_SHORT]);
        st_nxt.mod_lamps[`SSD_LAMP_IO]  = ext_now;

        // Sticky events
        ev[`SSD_IRQ_EXT_BIT]   = st_nxt.ext_fault & ~st_r.ext_fault;
        ev[`SSD_IRQ_INT_BIT]   = int_now & ~st_r.int_fault;
        ev[`SSD_IRQ_RELAY_BIT] = relay_now ^ st_r.relay_q;

        // Write channel
        if (s_axi_awvalid & ~st_r.aw_got) begin
            st_nxt.aw_got  = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid & ~st_r.w_got) begin
            st_nxt.w_got  = 1'b1;
            st_nxt.w_data = s_axi_wdata;
            st_nxt.w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got  = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp  = `SSD_RESP_OKAY;
            if (addr_hit(st_r.aw_addr, `SSD_OFF_CTRL)) begin
                if (st_r.w_strb[0]) begin
                    st_nxt.monitor_en = wr_merged[`SSD_CTRL_MON_BIT];
                end
            end else if (addr_hit(st_r.aw_addr, `SSD_OFF_IRQ_MASK)) begin
                if (st_r.w_strb[0]) begin
                    st_nxt.irq_mask = wr_merged[`SSD_IRQ_W-1:0];
                end
            end else if (!(addr_hit(st_r.aw_addr, `SSD_OFF_IMAGE) |
                           addr_hit(st_r.aw_addr, `SSD_OFF_MOD_STAT) |
                           addr_hit(st_r.aw_addr, `SSD_OFF_CHAN_STAT) |
                           addr_hit(st_r.aw_addr, `SSD_OFF_LAMPS) |
                           addr_hit(st_r.aw_addr, `SSD_OFF_IRQ_STAT))) begin
                st_nxt.bresp = `SSD_RESP_SLVERR;
            end
        end
        if (st_r.bvalid & s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read channel
        case (st_r.rd_state)
            SSD_RD_IDLE: begin
                if (rd_fire) begin
                    st_nxt.rd_state = SSD_RD_RESP;
                    st_nxt.rresp = `SSD_RESP_OKAY;
                    if (addr_hit(s_axi_araddr, `SSD_OFF_IMAGE)) begin
                        st_nxt.rdata = st_r.image;
                    end else if (addr_hit(s_axi_araddr, `SSD_OFF_MOD_STAT)) begin
                        st_nxt.rdata = mod_stat;
                    end else if (addr_hit(s_axi_araddr, `SSD_OFF_CHAN_STAT)) begin
                        st_nxt.rdata = chan_stat;
                    end else if (addr_hit(s_axi_araddr, `SSD_OFF_CTRL)) begin
                        st_nxt.rdata = {31'h0000_0000, st_r.monitor_en};
                    end else if (addr_hit(s_axi_araddr, `SSD_OFF_LAMPS)) begin
                        st_nxt.rdata = st_r.lamps;
                    end else if (addr_hit(s_axi_araddr, `SSD_OFF_IRQ_STAT)) begin
                        st_nxt.rdata = {29'h0000_0000, st_r.irq_stat};
                        st_nxt.irq_stat = '0;
                    end else if (addr_hit(s_axi_araddr, `SSD_OFF_IRQ_MASK)) begin
                        st_nxt.rdata = {29'h0000_0000, st_r.irq_mask};
                    end else begin
                        st_nxt.rdata = 32'h0000_0000;
                        st_nxt.rresp = `SSD_RESP_SLVERR;
                    end
                end
            end
            SSD_RD_RESP: begin
                if (s_axi_rready) begin
                    st_nxt.rd_state = SSD_RD_IDLE;
                end
            end
            default: begin
                st_nxt.rd_state = SSD_RD_IDLE;
            end
        endcase

        // Set wins over read-clear
        st_nxt.irq_stat = st_nxt.irq_stat | ev;
    end

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r            <= '0;
            st_r.monitor_en <= 1'(`SSD_CTRL_RST);
            st_r.irq_mask   <= `SSD_IRQ_W'(`SSD_MASK_RST);
            st_r.rd_state   <= SSD_RD_IDLE;
        end else if (clk_en) begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign display_lamp       = st_r.lamps;
    assign run_lamp           = st_r.mod_lamps[`SSD_LAMP_RUN];
    assign error_lamp         = st_r.mod_lamps[`SSD_LAMP_ERR];
    assign io_lamp            = st_r.mod_lamps[`SSD_LAMP_IO];
    assign module_error_flag  = st_r.ext_fault | st_r.int_fault;
    assign channel_error_flag = {32{st_r.ext_fault | st_r.int_fault}};
    assign irq                = |(st_r.irq_stat & st_r.irq_mask);

    assign s_axi_awready = ~st_r.aw_got;
    assign s_axi_wready  = ~st_r.w_got;
    assign s_axi_bvalid  = st_r.bvalid;
    assign s_axi_bresp   = st_r.bresp;
    assign s_axi_arready = (st_r.rd_state == SSD_RD_IDLE);
    assign s_axi_rvalid  = (st_r.rd_state == SSD_RD_RESP);
    assign s_axi_rdata   = st_r.rdata;
    assign s_axi_rresp   = st_r.rresp;

endmodule
`default_nettype wire

// ==== ssd_regs.svh ====
// Register offsets, field positions and reset values of the status display block.
// Assumes inclusion by bare name from the package and the design module.
`ifndef SSD_REGS_SVH
`define SSD_REGS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SSD_OFF_IMAGE      12'h000
`define SSD_OFF_MOD_STAT   12'h004
`define SSD_OFF_CHAN_STAT  12'h008
`define SSD_OFF_CTRL       12'h00C
`define SSD_OFF_LAMPS      12'h010
`define SSD_OFF_IRQ_STAT   12'h014
`define SSD_OFF_IRQ_MASK   12'h018

// ----------------------------------------
// Input image fields
// ----------------------------------------
`define SSD_NUM_CONTACTS   24
`define SSD_NUM_HALF       12
`define SSD_BIT_RESET_IN   24
`define SSD_BIT_LOOP       25
`define SSD_BIT_RELAY      26
`define SSD_BIT_SUPPLY     27
`define SSD_BIT_SHORT      28
`define SSD_BIT_EXT        29
`define SSD_BIT_INT        30
`define SSD_BIT_RUN        31
`define SSD_IMG_USED_MASK  32'h0FFF_FFFF

// ----------------------------------------
// Status word fields and module lamp positions
// ----------------------------------------
`define SSD_MOD_INT_BIT    0
`define SSD_MOD_EXT_BIT    1
`define SSD_CHAN_EXT_BIT   3
`define SSD_CHAN_INT_BIT   4
`define SSD_LAMP_RUN       0
`define SSD_LAMP_ERR       1
`define SSD_LAMP_IO        2

// ----------------------------------------
// Control, interrupt fields, reset values and response codes
// ----------------------------------------
`define SSD_CTRL_MON_BIT   0
`define SSD_CTRL_RST       32'h0000_0001
`define SSD_IRQ_EXT_BIT    0
`define SSD_IRQ_INT_BIT    1
`define SSD_IRQ_RELAY_BIT  2
`define SSD_IRQ_W          3
`define SSD_MASK_RST       32'h0000_0000
`define SSD_RESP_OKAY      2'h0
`define SSD_RESP_SLVERR    2'h2

`endif

// ==== ssd_pkg.sv ====
// Types of the status display block.
// Assumes ssd_regs.svh is on the include path.
`include "ssd_regs.svh"

package ssd_pkg;

    typedef enum logic [1:0] {
        SSD_RD_IDLE,
        SSD_RD_RESP
    } ssd_rd_e;

    typedef struct packed {
        logic [31:0]          in_sync1;
        logic [31:0]          in_sync2;
        logic [31:0]          image;
        logic [31:0]          lamps;
        logic [2:0]           mod_lamps;
        logic                 ext_fault;
        logic                 int_fault;
        logic                 relay_q;
        logic                 monitor_en;
        logic [`SSD_IRQ_W-1:0] irq_stat;
        logic [`SSD_IRQ_W-1:0] irq_mask;
        logic                 aw_got;
        logic                 w_got;
        logic [11:0]          aw_addr;
        logic [31:0]          w_data;
        logic [3:0]           w_strb;
        logic                 bvalid;
        logic [1:0]           bresp;
        ssd_rd_e              rd_state;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
    } ssd_state_s;

endpackage

// ==== ssd_chk.sv ====
// Concurrent checks on the status display ports.
// Assumes pin checks wait three running edges after reset or clk_en low; bound to every design instance.
`timescale 1ns/100ps
`default_nettype none
module ssd_chk (
    // Clock, reset, enable
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    // Field pins
    input wire logic [11:0] pos_contact_closed,
    input wire logic [11:0] neg_contact_closed,
    input wire logic        reset_input_closed,
    input wire logic        feedback_loop_closed,
    input wire logic        safety_supply_ok,
    input wire logic        channel_short,
    input wire logic        ext_supply_low,
    input wire logic        terminal_block_missing,
    input wire logic        internal_fault,
    // Lamps, flags, read channel
    input wire logic [31:0] display_lamp,
    input wire logic        error_lamp,
    input wire logic        io_lamp,
    input wire logic        module_error_flag,
    input wire logic [31:0] channel_error_flag,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Pipeline filled after reset
    logic [1:0] age_r;
    always_ff @(posedge aclk) begin
        if (!aresetn || !clk_en) age_r <= 2'h0;
        else if (age_r != 2'h3) age_r <= age_r + 2'h1;
    end
    sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
    sequence rd_wait; s_axi_rvalid && !s_axi_rready; endsequence
    a_contact_lamps: assert property (age_r == 2'h3 |->
        display_lamp[23:0] == {$past(neg_contact_closed, 3), $past(pos_contact_closed, 3)}) else $error("contact lamps");
    a_reset_lamp: assert property (age_r == 2'h3 |->
        display_lamp[24] == ($past(reset_input_closed, 3) && $past(feedback_loop_closed, 3))) else $error("reset lamp");
    a_loop_lamp: assert property (age_r == 2'h3 |->
        display_lamp[25] == $past(feedback_loop_closed, 3)) else $error("loop lamp");
    a_supply_lamp: assert property (age_r == 2'h3 |->
        display_lamp[27] == ($past(safety_supply_ok, 3) && !$past(channel_short, 3))) else $error("supply lamp");
    a_unused_dark: assert property (display_lamp[31:28] == 4'h0) else $error("unused lamps");
    a_io_lamp: assert property (age_r == 2'h3 |->
        io_lamp == ($past(ext_supply_low, 3) || $past(terminal_block_missing, 3))) else $error("io lamp");
    a_chan_flags: assert property (channel_error_flag == {32{module_error_flag}}) else $error("flags");
    a_int_error: assert property (age_r == 2'h3 && $past(internal_fault, 3) |->
        error_lamp && module_error_flag) else $error("internal fault");
    a_read_answer: assert property (rd_take |=> s_axi_rvalid) else $error("read answer");
    a_read_stable: assert property (rd_wait |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read hold");
endmodule
bind ssd_status_display ssd_chk ssd_chk_inst (.*);
`default_nettype wire

// ==== ssd_cpu.sv ====
// Controller model: AXI4-Lite master for register reads and writes.
// Assumes one call at a time, made from a clock edge.
`timescale 1ns/100ps
`default_nettype none
module ssd_cpu (
    // Clock
    input  wire logic        aclk,
    // Write channels
    output logic [11:0]      s_axi_awaddr,
    output logic             s_axi_awvalid,
    input  wire logic        s_axi_awready,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_wvalid,
    input  wire logic        s_axi_wready,
    input  wire logic        s_axi_bvalid,
    output logic             s_axi_bready,
    // Read channels
    output logic [11:0]      s_axi_araddr,
    output logic             s_axi_arvalid,
    input  wire logic        s_axi_arready,
    input  wire logic        s_axi_rvalid,
    output logic             s_axi_rready
);
    initial begin
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid} = '0;
        {s_axi_bready, s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    end
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_done;
        logic w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} <= {a, 1'b1, d, 4'hF};
        {s_axi_wvalid, s_axi_bready} <= 2'h3;
        while (!(aw_done && w_done)) begin
            @(posedge aclk);
            if (s_axi_awready && !aw_done) begin
                aw_done = 1'b1;
                {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
            end
            if (s_axi_wready && !w_done) begin
                w_done = 1'b1;
                {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~d};
            end
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge aclk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(posedge aclk); while (!s_axi_arready);
        {s_axi_araddr, s_axi_arvalid} <= {~a, 1'b0};
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ==== testbench.sv ====
// Self-checking bench for the status display block.
// Assumes ssd_cpu as bus partner and ssd_chk bound to the design.
`timescale 1ns/100ps
`default_nettype none
`include "ssd_regs.svh"
module testbench;
    logic        aclk, aresetn, clk_en, reset_input_closed, feedback_loop_closed, rack_run;
    logic [11:0] pos_contact_closed, neg_contact_closed, s_axi_awaddr, s_axi_araddr;
    logic        first_fault_relay_driven, second_fault_relay_driven, safety_supply_ok, channel_short;
    logic        ext_supply_low, terminal_block_missing, internal_fault, run_lamp, error_lamp, io_lamp;
    logic [31:0] display_lamp, channel_error_flag, s_axi_wdata, s_axi_rdata, seed, img, lmp;
    logic        module_error_flag, irq, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, ev;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [3:0]  tbl[5] = '{4'b1011, 4'b0100, 4'b0010, 4'b0110, 4'b1100};
    logic [33:0] rq[$];
    logic [1:0]  bq[$];
    int          fail_count, compares, cycles;
    ssd_status_display ssd_status_display_inst (.*);
    ssd_cpu ssd_cpu_inst (.*);
    initial aclk = 1'b0;
    always #5 aclk = ~aclk;
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        rq.push_back({r, d});
        ssd_cpu_inst.rd(a);
    endtask
    task automatic wr_chk(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        bq.push_back(r);
        ssd_cpu_inst.wr(a, d);
    endtask
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Image and lamps after pins settle
    task automatic expect_pins(input logic zero);
        repeat (4) @(posedge aclk);
        lmp = {4'h0, safety_supply_ok & ~channel_short, first_fault_relay_driven & second_fault_relay_driven,
               feedback_loop_closed, reset_input_closed & feedback_loop_closed, neg_contact_closed, pos_contact_closed};
        img = zero ? 32'h0000_0000 : {lmp[31:28], safety_supply_ok, lmp[26:0]};
        rd_chk(`SSD_OFF_IMAGE, img, `SSD_RESP_OKAY);
        rd_chk(`SSD_OFF_LAMPS, lmp, `SSD_RESP_OKAY);
        check(34'(display_lamp), 34'(lmp));
    endtask
    // Response monitor and timeout
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
        if (s_axi_rvalid && s_axi_rready) check({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid && s_axi_bready) check(34'(s_axi_bresp), 34'(bq.pop_front()));
    end
    initial begin
        {aresetn, pos_contact_closed, neg_contact_closed, reset_input_closed, feedback_loop_closed} = '0;
        {first_fault_relay_driven, second_fault_relay_driven, channel_short, ext_supply_low} = '0;
        {terminal_block_missing, internal_fault, ev, fail_count, compares, cycles} = '0;
        {clk_en, rack_run, safety_supply_ok, seed} = {3'h7, 32'h162e_faa8};
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`SSD_OFF_CTRL, `SSD_CTRL_RST, `SSD_RESP_OKAY);
        rd_chk(`SSD_OFF_IRQ_MASK, `SSD_MASK_RST, `SSD_RESP_OKAY);
        for (int i = 0; i < 10; i++) begin
            seed = xs(seed);
            ev = ev | ((seed[3] & seed[2]) != (first_fault_relay_driven & second_fault_relay_driven));
            {pos_contact_closed, neg_contact_closed, reset_input_closed, feedback_loop_closed} <= seed[29:4];
            {first_fault_relay_driven, second_fault_relay_driven, safety_supply_ok, channel_short} <= seed[3:0];
            expect_pins(1'b0);
        end
        rd_chk(`SSD_OFF_IRQ_STAT, {29'h0, ev, 2'h0}, `SSD_RESP_OKAY);
        wr_chk(`SSD_OFF_IRQ_MASK, 32'h0000_0001, `SSD_RESP_OKAY);
        for (int k = 0; k < 2; k++) begin
            {ext_supply_low, terminal_block_missing, channel_short} <= {k == 0, k == 1, 1'b0};
            expect_pins(1'b1);
            check({irq, module_error_flag, channel_error_flag}, {2'h3, 32'hFFFF_FFFF});
            check(34'({error_lamp, io_lamp}), 34'h0_0000_0001);
            rd_chk(`SSD_OFF_MOD_STAT, 32'h0000_0002, `SSD_RESP_OKAY);
            rd_chk(`SSD_OFF_CHAN_STAT, 32'h0000_0008, `SSD_RESP_OKAY);
            rd_chk(`SSD_OFF_IRQ_STAT, 32'h0000_0001, `SSD_RESP_OKAY);
            {ext_supply_low, terminal_block_missing} <= 2'h0;
            repeat (5) @(posedge aclk);
            check(34'(irq), 34'h0_0000_0000);
            check(34'({run_lamp, error_lamp, io_lamp}), 34'h0_0000_0004);
        end
        wr_chk(`SSD_OFF_IRQ_MASK, 32'h0000_0000, `SSD_RESP_OKAY);
        for (int k = 0; k < 5; k++) begin
            {rack_run, internal_fault, ext_supply_low, channel_short} <= tbl[k];
            repeat (5) @(posedge aclk);
            check(34'({error_lamp, io_lamp}), 34'({tbl[k][2] | &{tbl[k][3], tbl[k][1:0]}, tbl[k][1]}));
            check(34'(run_lamp), 34'(tbl[k][3]));
        end
        check(34'(irq), 34'h0_0000_0000);
        rd_chk(`SSD_OFF_MOD_STAT, 32'h0000_0001, `SSD_RESP_OKAY);
        rd_chk(`SSD_OFF_CHAN_STAT, 32'h0000_0010, `SSD_RESP_OKAY);
        rd_chk(`SSD_OFF_IRQ_STAT, 32'h0000_0003, `SSD_RESP_OKAY);
        {internal_fault, ext_supply_low} <= 2'h1;
        wr_chk(`SSD_OFF_CTRL, 32'h0000_0000, `SSD_RESP_OKAY);
        expect_pins(1'b0);
        check(34'(module_error_flag), 34'h0_0000_0000);
        rd_chk(`SSD_OFF_MOD_STAT, 32'h0000_0000, `SSD_RESP_OKAY);
        wr_chk(`SSD_OFF_IMAGE, 32'hFFFF_FFFF, `SSD_RESP_OKAY);
        wr_chk(12'h01C, 32'h0000_0001, `SSD_RESP_SLVERR);
        rd_chk(12'h01C, 32'h0000_0000, `SSD_RESP_SLVERR);
        repeat (3) @(posedge aclk);
        // Freeze with clk_en low, then a second reset
        lmp = display_lamp;
        {clk_en, feedback_loop_closed} <= {1'b0, ~feedback_loop_closed};
        repeat (5) @(posedge aclk);
        check(34'(display_lamp), 34'(lmp));
        clk_en <= 1'b1;
        expect_pins(1'b0);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(`SSD_OFF_CTRL, `SSD_CTRL_RST, `SSD_RESP_OKAY);
        expect_pins(1'b1);
        repeat (3) @(posedge aclk);
        final_report();
    end
endmodule
`default_nettype wire
